/* hw/aior_pkg.sv */
// Operation
// - reading board status clears latched events; global-enable mirror bit stays
// - bit 7 latches on conversion done, bit 6 on any port C change
// - any write to offset zero clears the pending interrupt condition
// - offset one reads interrupt status, writes a separate enable register
// - interrupt pin pulled low 500 ns, driven high briefly, then released
// - no further interrupt until cleared; unread conversion or toggle data keeps its source pending
// - remaining uncleared enabled events raise a fresh interrupt after clear
// - enable bit 2 gates all interrupts, low at reset; status bit 2 shows raised
// - conversion interrupt serviced by reading both result bytes plus clear write
// - toggle interrupt serviced by reading toggle register plus clear write
// - enable bit 5: interrupt on counter 1 falling edge, held until clear
// - enable bits 4 and 3: rising edges of port C lines 3 and 0
// - toggle register ORs in changed lines, returns then clears on read
// - control byte write at offset two starts a conversion, fields as listed
// - standby restarts at once; full power-down costs 50 ms before converting
// - acquisition bit high holds sampling until byte with bit 5 low, same channel
// - range doubles span, bit 3 bipolar, bits 2:0 pick one of eight inputs
// - offset two reads latest 12-bit result, word or byte at two and three
// - word writes at 4, 6, 8, A update converter outputs from low 12 bits
// - reset disables the output reference until software enables it at 18h
// - with sync trigger enabled, data writes hold; all outputs update on tick
// - registers decoded on A4..A0 below a base matched on A9..A5
// - trigger tick is counter 1; enable bit 1 starts conversions, bit 0 outputs
// - counter-started conversions use stored command, low five bits only
package aior_pkg;
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_IRQ = 5'h01;
  localparam logic [4:0] OFF_ADC_LO = 5'h02;
  localparam logic [4:0] OFF_ADC_HI = 5'h03;
  localparam logic [4:0] OFF_DAC_BASE = 5'h04;
  localparam logic [4:0] OFF_ADC_CMD = 5'h15;
  localparam logic [4:0] OFF_TRIG_EN = 5'h16;
  localparam logic [4:0] OFF_COS = 5'h17;
  localparam logic [4:0] OFF_REF = 5'h18;
  localparam int BIT_ADC = 7;
  localparam int BIT_COS = 6;
  localparam int BIT_CTR = 5;
  localparam int BIT_C3 = 4;
  localparam int BIT_C0 = 3;
  localparam int BIT_GLOBAL = 2;
  localparam int PC_LINE3 = 3;
  localparam int PC_LINE0 = 0;
  localparam int TRIG_ADC_BIT = 1;
  localparam int TRIG_DAC_BIT = 0;
  localparam int REF_BIT = 0;
  localparam int CTL_ACQ_BIT = 5;
  localparam int CTL_MODE_LSB = 6;
  localparam logic [7:0] CTL_CHAN_MASK = 8'h07;
  localparam logic [7:0] CMD_MASK = 8'h1F;
  localparam logic [7:0] IRQ_SRC_MASK = 8'hF8;
  localparam logic [1:0] MODE_FULL_DOWN = 2'h3;
  localparam int NUM_DAC = 4;
  localparam int ADC_BITS = 12;
  localparam int CLK_NS = 8;
  localparam int IRQ_LOW_NS = 500;
  localparam int IRQ_HIGH_NS = 16;
  localparam int ADC_STARTUP_MS = 50;
  localparam int IRQ_LOW_CYC = (IRQ_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int IRQ_HIGH_CYC = (IRQ_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADC_STARTUP_CYC = ADC_STARTUP_MS * (1000000 / CLK_NS);
  typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULL_LOW, IRQ_DRIVE_HIGH} aior_irq_state_t;
  typedef enum logic [1:0] {ADC_IDLE, ADC_WARMUP, ADC_HOLD, ADC_CONVERT} aior_adc_state_t;
endpackage : aior_pkg

/* hw/aior_regs.sv */
`timescale 1ns/1ns
module aior_regs #(
  parameter int STARTUP_CYCLES = aior_pkg::ADC_STARTUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] base_sel,
  input wire logic [9:0] bus_addr,
  input wire logic bus_aen,
  input wire logic bus_ior_n,
  input wire logic bus_iow_n,
  input wire logic bus_sbhe_n,
  input wire logic [15:0] bus_data_in,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe,
  output logic irq_out,
  output logic irq_oe,
  output logic adc_ctl_wr,
  output logic [7:0] adc_ctl_byte,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic adc_busy,
  input wire logic [7:0] port_c,
  input wire logic counter1_out,
  output logic [11:0] dac_value [aior_pkg::NUM_DAC],
  output logic dac_ref_en
);
  localparam logic [5:0] IRQ_LOW_LD = 6'(aior_pkg::IRQ_LOW_CYC - 1);
  localparam logic [5:0] IRQ_HIGH_LD = 6'(aior_pkg::IRQ_HIGH_CYC - 1);
  localparam logic [22:0] STARTUP_LD = 23'(STARTUP_CYCLES - 1);

  logic ior_q, iow_q;
  logic [7:0] port_c_q;
  logic ctr_q;
  logic ev_adc, ev_cos;
  logic [7:0] irq_en;
  logic [7:0] pend;
  logic irq_fired;
  logic [7:0] cos_acc;
  logic cos_read;
  logic adc_got_lo, adc_got_hi;
  logic [11:0] result;
  logic [7:0] adc_cmd;
  logic [7:0] trig_en;
  logic [7:0] dac_lo [aior_pkg::NUM_DAC];
  logic [11:0] dac_stage [aior_pkg::NUM_DAC];
  logic powered_down;
  logic [2:0] hold_chan;
  logic [22:0] warm_cnt;
  logic [5:0] irq_cnt;
  aior_pkg::aior_irq_state_t irq_state;
  aior_pkg::aior_adc_state_t adc_state;

  // decode: jumper base on A9..A5, register on A4..A0
  wire selected = !bus_aen && (bus_addr[9:5] == base_sel);
  wire [4:0] off = bus_addr[4:0];
  wire [4:0] off_hi = off + 5'h01;
  wire word = !bus_sbhe_n && !off[0];
  wire rd_go = selected && !bus_ior_n && ior_q;
  wire wr_go = selected && !bus_iow_n && iow_q;

  function automatic logic hit_lo(input logic [4:0] a, input logic [4:0] o);
    return a == o;
  endfunction : hit_lo

  function automatic logic hit_any(input logic [4:0] a, input logic [4:0] ah, input logic w,
                                   input logic [4:0] o);
    return (a == o) || (w && ah == o);
  endfunction : hit_any

  wire [7:0] wr_lo_val = bus_data_in[7:0];
  wire [7:0] wr_hi_val = bus_data_in[15:8];
  wire rd_status = rd_go && hit_lo(off, aior_pkg::OFF_STATUS);
  wire rd_cos = rd_go && hit_any(off, off_hi, word, aior_pkg::OFF_COS);
  wire rd_adc_lo = rd_go && hit_lo(off, aior_pkg::OFF_ADC_LO);
  wire rd_adc_hi = rd_go && hit_any(off, off_hi, word, aior_pkg::OFF_ADC_HI);
  wire irq_clr = wr_go && hit_lo(off, aior_pkg::OFF_STATUS);
  wire wr_irq_en = wr_go && hit_lo(off, aior_pkg::OFF_IRQ);
  wire wr_ctl = wr_go && hit_lo(off, aior_pkg::OFF_ADC_LO);
  wire wr_cmd = wr_go && hit_lo(off, aior_pkg::OFF_ADC_CMD);
  wire wr_trig = wr_go && hit_lo(off, aior_pkg::OFF_TRIG_EN);
  wire wr_ref = wr_go && hit_lo(off, aior_pkg::OFF_REF);

  // events seen on the sampled inputs
  wire [7:0] pc_change = port_c ^ port_c_q;
  wire cos_any = |pc_change;
  wire ctr_fall = ctr_q && !counter1_out;
  wire c3_rise = port_c[aior_pkg::PC_LINE3] && !port_c_q[aior_pkg::PC_LINE3];
  wire c0_rise = port_c[aior_pkg::PC_LINE0] && !port_c_q[aior_pkg::PC_LINE0];
  wire [7:0] src_event = {adc_done, cos_any, ctr_fall, c3_rise, c0_rise, 3'b000};
  wire [7:0] pend_set = src_event & irq_en & aior_pkg::IRQ_SRC_MASK;

  // conversion and toggle sources stay pending until their data has also been read
  wire adc_serviced = adc_got_lo && adc_got_hi;
  wire [7:0] svc_mask = {adc_serviced, cos_read, 6'b111111};
  wire [7:0] next_pend = (irq_clr ? (pend & ~svc_mask) : pend) | pend_set;
  wire global_en = irq_en[aior_pkg::BIT_GLOBAL];
  wire fire = global_en && !irq_fired && (|pend) &&
              (irq_state == aior_pkg::IRQ_IDLE);

  // register readback
  wire [7:0] status_byte = {ev_adc, ev_cos, 3'b000, global_en, 2'b00};
  wire [7:0] irq_byte = {pend[7:3], irq_fired, 2'b00};

  function automatic logic [7:0] reg_byte(input logic [4:0] o, input logic [7:0] st,
                                          input logic [7:0] ib, input logic [11:0] res,
                                          input logic [7:0] port_c_toggle_detect);
    case (o)
      aior_pkg::OFF_STATUS: return st;
      aior_pkg::OFF_IRQ: return ib;
      aior_pkg::OFF_ADC_LO: return res[7:0];
      aior_pkg::OFF_ADC_HI: return {4'h0, res[11:8]};
      aior_pkg::OFF_COS: return port_c_toggle_detect;
      default: return 8'h00;
    endcase
  endfunction : reg_byte

  wire [7:0] rd_lo_byte = reg_byte(off, status_byte, irq_byte, result, cos_acc);
  wire [7:0] rd_hi_byte = reg_byte(off_hi, status_byte, irq_byte, result, cos_acc);
  wire [15:0] rd_word = word ? {rd_hi_byte, rd_lo_byte} : {8'h00, rd_lo_byte};

  // conversion starts: host byte, or stored command on the counter tick
  wire ctr_adc = ctr_fall && trig_en[aior_pkg::TRIG_ADC_BIT];
  wire [7:0] ctr_byte = adc_cmd & aior_pkg::CMD_MASK;
  wire chan_same = (wr_lo_val[2:0] == hold_chan);
  wire hold_release = wr_ctl && !wr_lo_val[aior_pkg::CTL_ACQ_BIT];
  wire host_start = wr_ctl &&
                    !(adc_state == aior_pkg::ADC_HOLD && hold_release && !chan_same);
  wire start = host_start || (ctr_adc && !wr_ctl);
  wire [7:0] start_byte = host_start ? wr_lo_val : ctr_byte;
  wire start_acq = start_byte[aior_pkg::CTL_ACQ_BIT];
  wire [1:0] start_mode = start_byte[aior_pkg::CTL_MODE_LSB +: 2];
  wire dac_tick = ctr_fall && trig_en[aior_pkg::TRIG_DAC_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ior_q <= 1'b1;
      iow_q <= 1'b1;
      port_c_q <= 8'h00;
      ctr_q <= 1'b1;
    end else begin
      ior_q <= bus_ior_n;
      iow_q <= bus_iow_n;
      port_c_q <= port_c;
      ctr_q <= counter1_out;
    end
  end

  // set wins over clear on every latched flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_adc <= 1'b0;
      ev_cos <= 1'b0;
      cos_acc <= 8'h00;
      pend <= 8'h00;
    end else begin
      ev_adc <= (ev_adc && !rd_status) || adc_done;
      ev_cos <= (ev_cos && !rd_status) || cos_any;
      cos_acc <= (rd_cos ? 8'h00 : cos_acc) | pc_change;
      pend <= next_pend;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en <= 8'h00;
      irq_fired <= 1'b0;
      trig_en <= 8'h00;
      adc_cmd <= 8'h00;
      dac_ref_en <= 1'b0;
    end else begin
      if (wr_irq_en) irq_en <= wr_lo_val & ~8'h03;
      if (fire) irq_fired <= 1'b1;
      else if (irq_clr) irq_fired <= 1'b0;
      if (wr_trig) trig_en <= wr_lo_val;
      if (wr_cmd) adc_cmd <= wr_lo_val & aior_pkg::CMD_MASK;
      if (wr_ref) dac_ref_en <= wr_lo_val[aior_pkg::REF_BIT];
    end
  end

  // a fresh conversion invalidates earlier data reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_got_lo <= 1'b0;
      adc_got_hi <= 1'b0;
      cos_read <= 1'b0;
      result <= 12'h000;
    end else begin
      adc_got_lo <= adc_done ? 1'b0 : (adc_got_lo || rd_adc_lo);
      adc_got_hi <= adc_done ? 1'b0 : (adc_got_hi || rd_adc_hi);
      cos_read <= cos_any ? 1'b0 : (cos_read || rd_cos);
      if (adc_done) result <= adc_result;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_data_out <= 16'h0000;
    end else if (rd_go) begin
      bus_data_out <= rd_word;
    end
  end

  assign bus_data_oe = selected && !bus_ior_n;

  // shared line: pull low, drive high to sharpen the edge, then let go
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_state <= aior_pkg::IRQ_IDLE;
      irq_cnt <= 6'h00;
      irq_out <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      case (irq_state)
        aior_pkg::IRQ_IDLE: begin
          if (fire) begin
            irq_state <= aior_pkg::IRQ_PULL_LOW;
            irq_cnt <= IRQ_LOW_LD;
            irq_out <= 1'b0;
            irq_oe <= 1'b1;
          end
        end
        aior_pkg::IRQ_PULL_LOW: begin
          if (irq_cnt == 6'h00) begin
            irq_state <= aior_pkg::IRQ_DRIVE_HIGH;
            irq_cnt <= IRQ_HIGH_LD;
            irq_out <= 1'b1;
          end else begin
            irq_cnt <= irq_cnt - 6'h01;
          end
        end
        aior_pkg::IRQ_DRIVE_HIGH: begin
          if (irq_cnt == 6'h00) begin
            irq_state <= aior_pkg::IRQ_IDLE;
            irq_oe <= 1'b0;
          end else begin
            irq_cnt <= irq_cnt - 6'h01;
          end
        end
        default: begin
          irq_state <= aior_pkg::IRQ_IDLE;
          irq_oe <= 1'b0;
        end
      endcase
    end
  end

  // converter tracking; every accepted byte is forwarded unchanged to the converter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_state <= aior_pkg::ADC_IDLE;
      adc_ctl_wr <= 1'b0;
      adc_ctl_byte <= 8'h00;
      powered_down <= 1'b0;
      hold_chan <= 3'h0;
      warm_cnt <= 23'h000000;
    end else begin
      adc_ctl_wr <= start;
      if (start) begin
        adc_ctl_byte <= start_byte;
        hold_chan <= start_byte[2:0];
        powered_down <= (start_mode == aior_pkg::MODE_FULL_DOWN);
      end
      case (adc_state)
        aior_pkg::ADC_IDLE, aior_pkg::ADC_CONVERT, aior_pkg::ADC_HOLD: begin
          if (start && powered_down) begin
            adc_state <= aior_pkg::ADC_WARMUP;
            warm_cnt <= STARTUP_LD;
          end else if (start) begin
            adc_state <= start_acq ? aior_pkg::ADC_HOLD : aior_pkg::ADC_CONVERT;
          end else if (adc_done && adc_state == aior_pkg::ADC_CONVERT) begin
            adc_state <= aior_pkg::ADC_IDLE;
          end
        end
        aior_pkg::ADC_WARMUP: begin
          if (warm_cnt == 23'h000000) begin
            adc_state <= adc_ctl_byte[aior_pkg::CTL_ACQ_BIT] ? aior_pkg::ADC_HOLD
                                                             : aior_pkg::ADC_CONVERT;
          end else begin
            warm_cnt <= warm_cnt - 23'h000001;
          end
        end
        default: adc_state <= aior_pkg::ADC_IDLE;
      endcase
    end
  end

  assign adc_busy = (adc_state != aior_pkg::ADC_IDLE);

  // byte writes stage the low half; the high half commits the 12-bit value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < aior_pkg::NUM_DAC; n++) begin
        dac_lo[n] <= 8'h00;
        dac_stage[n] <= 12'h000;
        dac_value[n] <= 12'h000;
      end
    end else begin
      for (int n = 0; n < aior_pkg::NUM_DAC; n++) begin
        if (wr_go && off == aior_pkg::OFF_DAC_BASE + 5'(2 * n)) begin
          dac_lo[n] <= wr_lo_val;
          if (word) begin
            dac_stage[n] <= {wr_hi_val[3:0], wr_lo_val};
            if (!trig_en[aior_pkg::TRIG_DAC_BIT]) dac_value[n] <= {wr_hi_val[3:0], wr_lo_val};
          end
        end else if (wr_go && off == aior_pkg::OFF_DAC_BASE + 5'(2 * n + 1)) begin
          dac_stage[n] <= {wr_lo_val[3:0], dac_lo[n]};
          if (!trig_en[aior_pkg::TRIG_DAC_BIT]) dac_value[n] <= {wr_lo_val[3:0], dac_lo[n]};
        end else if (dac_tick) begin
          dac_value[n] <= dac_stage[n];
        end
      end
    end
  end

  sequence s_pull_low;
    irq_oe && !irq_out;
  endsequence

  sequence s_drive_high;
    irq_oe && irq_out;
  endsequence

  property p_status_clear;
    @(posedge clk) disable iff (rst)
      rd_status && !adc_done && !cos_any |=> !ev_adc && !ev_cos && $stable(global_en);
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared");

  property p_adc_event;
    @(posedge clk) disable iff (rst) adc_done |=> ev_adc;
  endproperty
  a_adc_event: assert property (p_adc_event) else $error("adc event lost");

  property p_cos_event_on_read;
    @(posedge clk) disable iff (rst) rd_status && cos_any |=> ev_cos;
  endproperty
  a_cos_event_on_read: assert property (p_cos_event_on_read) else $error("cos event lost");

  property p_irq_shape;
    @(posedge clk) disable iff (rst)
      fire |=> s_pull_low [*8] ##55 s_pull_low ##1 s_drive_high ##2 !irq_oe;
  endproperty
  a_irq_shape: assert property (p_irq_shape) else $error("irq pulse shape wrong");

  property p_no_irq_disabled;
    @(posedge clk) disable iff (rst) !global_en |=> !$rose(irq_fired);
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");

  property p_clear_release;
    @(posedge clk) disable iff (rst) irq_clr && !fire |=> !irq_fired;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("clear ignored");

  property p_hold_fired;
    @(posedge clk) disable iff (rst) irq_fired && !irq_clr |=> irq_fired && !$rose(irq_oe);
  endproperty
  a_hold_fired: assert property (p_hold_fired) else $error("second irq too soon");

  property p_cos_accum;
    @(posedge clk) disable iff (rst) cos_any |=> (cos_acc & $past(pc_change)) == $past(pc_change);
  endproperty
  a_cos_accum: assert property (p_cos_accum) else $error("toggle not accumulated");

  property p_ctl_start;
    @(posedge clk) disable iff (rst)
      wr_ctl && adc_state == aior_pkg::ADC_IDLE
      |=> adc_ctl_wr && adc_ctl_byte == $past(wr_lo_val);
  endproperty
  a_ctl_start: assert property (p_ctl_start) else $error("control byte not forwarded");

  property p_dac_word;
    @(posedge clk) disable iff (rst)
      wr_go && word && off == aior_pkg::OFF_DAC_BASE && !trig_en[aior_pkg::TRIG_DAC_BIT]
      |=> dac_value[0] == $past(bus_data_in[11:0]);
  endproperty
  a_dac_word: assert property (p_dac_word) else $error("dac not updated");

  property p_dac_hold;
    @(posedge clk) disable iff (rst)
      trig_en[aior_pkg::TRIG_DAC_BIT] && !dac_tick && !wr_trig |=> $stable(dac_value[1]);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac moved without tick");
endmodule : aior_regs

/* test/aior_host.sv */
`timescale 1ns/1ns
module aior_host (
  input wire logic clk,
  input wire logic [4:0] base_sel,
  input wire logic [15:0] bus_data_out,
  output logic [9:0] bus_addr,
  output logic bus_aen,
  output logic bus_ior_n,
  output logic bus_iow_n,
  output logic bus_sbhe_n,
  output logic [15:0] bus_data_in
);
  initial begin
    bus_addr = 10'h000;
    bus_aen = 1'b0;
    bus_ior_n = 1'b1;
    bus_iow_n = 1'b1;
    bus_sbhe_n = 1'b1;
    bus_data_in = 16'h0000;
  end

  // strobe held across the take edge and the answer edge, then a full high cycle
  task automatic bus_xfer(input logic wr, input logic [4:0] off, input logic word,
                          input logic [15:0] d, output logic [15:0] q);
    @(negedge clk);
    bus_addr = {base_sel, off};
    bus_sbhe_n = ~word;
    bus_data_in = d;
    if (wr) begin
      bus_iow_n = 1'b0;
    end else begin
      bus_ior_n = 1'b0;
    end
    @(posedge clk);
    @(posedge clk);
    @(negedge clk);
    q = bus_data_out;
    bus_iow_n = 1'b1;
    bus_ior_n = 1'b1;
    bus_sbhe_n = 1'b1;
    // undriven data lines show the inverse so stale data cannot pass
    bus_data_in = ~d;
  endtask : bus_xfer
endmodule : aior_host

/* test/tb.sv */
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [4:0] off;
    logic [15:0] din;
    logic [1:0] idx;
    logic [11:0] expv;
  } aior_row_t;
  localparam logic [4:0] BASE = 5'h16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] bus_addr;
  logic bus_aen, bus_ior_n, bus_iow_n, bus_sbhe_n;
  logic [15:0] bus_data_in, bus_data_out, q;
  logic bus_data_oe, irq_out, irq_oe, adc_ctl_wr, adc_busy, dac_ref_en;
  logic [7:0] adc_ctl_byte, ctl_last;
  logic adc_done = 1'b0;
  logic [11:0] adc_result = 12'h000;
  logic [7:0] port_c = 8'h00;
  logic counter1_out = 1'b1;
  logic [11:0] dac_value [aior_pkg::NUM_DAC];
  int failures = 0;
  int n_compared = 0;
  int ctl_cnt = 0;
  int irq_cnt = 0;
  int lo, hi;
  int run_lo = 0;
  int run_hi = 0;
  int last_lo = 0;
  int last_hi = 0;
  logic oe_seen = 1'b0;
  logic oe_idle_bad = 1'b0;
  aior_row_t rows [4] = '{
    '{5'h04, 16'hF123, 2'd0, 12'h123}, '{5'h06, 16'h0FFF, 2'd1, 12'hFFF},
    '{5'h08, 16'hA000, 2'd2, 12'h000}, '{5'h0A, 16'h5ABC, 2'd3, 12'hABC}};

  always #4 clk = ~clk;

  aior_regs #(.STARTUP_CYCLES(20)) aior_regs_inst (
    .clk(clk), .rst(rst), .base_sel(BASE), .bus_addr(bus_addr), .bus_aen(bus_aen),
    .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n), .bus_sbhe_n(bus_sbhe_n),
    .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .irq_out(irq_out), .irq_oe(irq_oe), .adc_ctl_wr(adc_ctl_wr),
    .adc_ctl_byte(adc_ctl_byte), .adc_done(adc_done), .adc_result(adc_result),
    .adc_busy(adc_busy), .port_c(port_c), .counter1_out(counter1_out),
    .dac_value(dac_value), .dac_ref_en(dac_ref_en));

  aior_host aior_host_inst (
    .clk(clk), .base_sel(BASE), .bus_data_out(bus_data_out), .bus_addr(bus_addr),
    .bus_aen(bus_aen), .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n),
    .bus_sbhe_n(bus_sbhe_n), .bus_data_in(bus_data_in));

  always @(posedge clk) if (adc_ctl_wr === 1'b1) begin
    ctl_cnt++;
    ctl_last = adc_ctl_byte;
  end
  always @(posedge irq_oe) irq_cnt++;

  // pulse lengths are measured from the first driven cycle, whenever the bench looks
  always @(negedge clk) begin
    if (irq_oe === 1'b1 && irq_out === 1'b0) begin
      run_lo++;
    end else if (irq_oe === 1'b1) begin
      run_hi++;
    end else if (run_lo != 0 || run_hi != 0) begin
      last_lo = run_lo;
      last_hi = run_hi;
      run_lo = 0;
      run_hi = 0;
    end
  end

  always @(posedge clk) begin
    if (bus_ior_n === 1'b0) begin
      oe_seen = bus_data_oe;
    end else if (bus_data_oe !== 1'b0) begin
      oe_idle_bad = 1'b1;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] expv, input string what);
    n_compared++;
    if (got !== expv) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, expv);
    end
  endtask : check

  task automatic wr(input logic [4:0] off, input logic [15:0] d, input logic word);
    aior_host_inst.bus_xfer(1'b1, off, word, d, q);
  endtask : wr

  // byte reads compare the low lane only
  task automatic rd_chk(input logic [4:0] off, input logic word, input logic [15:0] expv);
    oe_seen = 1'b0;
    aior_host_inst.bus_xfer(1'b0, off, word, 16'h0000, q);
    check(word ? q : {8'h00, q[7:0]}, expv, "register read");
    check({15'h0, oe_seen}, 16'h0001, "data driven during read");
  endtask : rd_chk

  task automatic tick();
    @(negedge clk);
    counter1_out = 1'b0;
    repeat (3) @(negedge clk);
    counter1_out = 1'b1;
  endtask : tick

  task automatic adc_fin(input logic [11:0] res);
    @(negedge clk);
    adc_done = 1'b1;
    adc_result = res;
    @(negedge clk);
    adc_done = 1'b0;
  endtask : adc_fin

  task automatic wait_irq(output int nlo, output int nhi);
    int n;
    n = 0;
    while (irq_oe !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    while (irq_oe === 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    nlo = last_lo;
    nhi = last_hi;
  endtask : wait_irq

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check({15'h0, irq_oe}, 16'h0000, "irq idle after reset");
    check({15'h0, dac_ref_en}, 16'h0000, "reference off after reset");
    check({4'h0, dac_value[0]}, 16'h0000, "output code after reset");
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].off, rows[i].din, 1'b1);
      check({4'h0, dac_value[rows[i].idx]}, {4'h0, rows[i].expv}, "output code");
    end
    check({15'h0, dac_ref_en}, 16'h0000, "reference still off");
    wr(5'h18, 16'h0001, 1'b0);
    check({15'h0, dac_ref_en}, 16'h0001, "reference on");
    rd_chk(5'h04, 1'b1, 16'h0000);
    rd_chk(5'h1F, 1'b0, 16'h0000);
    $display("output test done");
    wr(5'h02, 16'h0023, 1'b0);
    check(ctl_cnt[15:0], 16'd1, "control byte sent");
    check({8'h00, ctl_last}, 16'h0023, "control byte value");
    check({15'h0, adc_busy}, 16'h0001, "converter busy");
    wr(5'h02, 16'h0001, 1'b0);
    check(ctl_cnt[15:0], 16'd1, "other channel ignored in hold");
    wr(5'h02, 16'h0003, 1'b0);
    check({8'h00, ctl_last}, 16'h0003, "hold ended");
    adc_fin(12'hABC);
    check(irq_cnt[15:0], 16'd0, "no interrupt while globally off");
    rd_chk(5'h00, 1'b0, 16'h0080);
    rd_chk(5'h00, 1'b0, 16'h0000);
    rd_chk(5'h02, 1'b1, 16'h0ABC);
    rd_chk(5'h03, 1'b0, 16'h000A);
    $display("conversion test done");
    wr(5'h01, 16'h00FF, 1'b0);
    rd_chk(5'h00, 1'b0, 16'h0004);
    port_c = 8'h50;
    repeat (2) @(negedge clk);
    port_c = 8'h40;
    repeat (2) @(negedge clk);
    port_c = 8'h60;
    wait_irq(lo, hi);
    check(lo[15:0], 16'd63, "line low cycles");
    check(hi[15:0], 16'd2, "line high cycles");
    rd_chk(5'h01, 1'b0, 16'h0044);
    rd_chk(5'h00, 1'b0, 16'h0044);
    rd_chk(5'h00, 1'b0, 16'h0004);
    rd_chk(5'h17, 1'b0, 16'h0070);
    rd_chk(5'h17, 1'b0, 16'h0000);
    wr(5'h00, 16'h00A5, 1'b0);
    rd_chk(5'h01, 1'b0, 16'h0000);
    $display("toggle interrupt test done");
    wr(5'h02, 16'h0000, 1'b0);
    adc_fin(12'h123);
    tick();
    wait_irq(lo, hi);
    rd_chk(5'h01, 1'b0, 16'h00A4);
    wr(5'h00, 16'h0000, 1'b0);
    wait_irq(lo, hi);
    check(irq_cnt[15:0], 16'd3, "fresh interrupt for remaining event");
    rd_chk(5'h01, 1'b0, 16'h0084);
    rd_chk(5'h02, 1'b0, 16'h0023);
    rd_chk(5'h03, 1'b0, 16'h0001);
    wr(5'h00, 16'h0000, 1'b0);
    repeat (80) @(negedge clk);
    check(irq_cnt[15:0], 16'd3, "no interrupt once serviced");
    rd_chk(5'h01, 1'b0, 16'h0000);
    port_c = 8'h61;
    wait_irq(lo, hi);
    rd_chk(5'h01, 1'b0, 16'h004C);
    rd_chk(5'h17, 1'b0, 16'h0001);
    wr(5'h00, 16'h0000, 1'b0);
    rd_chk(5'h01, 1'b0, 16'h0000);
    $display("interrupt test done");
    wr(5'h01, 16'h0000, 1'b0);
    wr(5'h16, 16'h0003, 1'b0);
    wr(5'h15, 16'h00FF, 1'b0);
    wr(5'h04, 16'h0555, 1'b1);
    check({4'h0, dac_value[0]}, 16'h0123, "write held back");
    tick();
    repeat (2) @(negedge clk);
    check({4'h0, dac_value[0]}, 16'h0555, "update on tick");
    check({4'h0, dac_value[1]}, 16'h0FFF, "other output kept");
    check(ctl_cnt[15:0], 16'd4, "tick starts conversion");
    check({8'h00, ctl_last}, 16'h001F, "stored command low five bits");
    $display("trigger test done");
    wr(5'h02, 16'h00C0, 1'b0);
    adc_fin(12'h000);
    wr(5'h02, 16'h0000, 1'b0);
    adc_fin(12'h456);
    check({15'h0, adc_busy}, 16'h0001, "done ignored during start-up");
    repeat (25) @(negedge clk);
    adc_fin(12'h456);
    check({15'h0, adc_busy}, 16'h0000, "converter idle after start-up");
    check({15'h0, oe_idle_bad}, 16'h0000, "data driven outside reads");
    $display("power-down test done");
    give_verdict();
  end
endmodule : tb
